/* File: verilog/senctl_pkg.sv */
package senctl_pkg;

	////////////////////////////////////////////////////////////////////////
	// Host address map (byte addresses on the expansion slot)
	localparam logic [31:0] CTRL_ADDR = 32'h2900_0000;
	localparam logic [31:0] X_ZERO_ADDR = 32'h2900_0004;
	localparam logic [31:0] Y_ZERO_ADDR = 32'h2900_0008;
	localparam logic [31:0] BATT_ADDR = 32'h2900_000c;
	localparam logic [31:0] X_SET_ADDR = 32'h2900_0012;
	localparam logic [31:0] Y_SET_ADDR = 32'h2900_001a;
	localparam logic [31:0] X_RST_ADDR = 32'h2900_0022;
	localparam logic [31:0] Y_RST_ADDR = 32'h2900_002a;
	localparam logic [31:0] TEMP_ADDR = 32'h2900_0032;
	localparam logic [31:0] PRES_ADDR = 32'h2900_0042;
	localparam logic [31:0] HALFWORD_STEP = 32'h0000_0002;

	////////////////////////////////////////////////////////////////////////
	// Control and status register layout
	localparam int EXEC_BIT = 5;
	localparam int DONE_BIT = 4;
	localparam int BATT_BIT = 2;
	localparam int RANGE_HI_BIT = 1;
	localparam int RANGE_LO_BIT = 0;
	localparam logic DONE_RESET = 1'h1;
	localparam logic BATT_RESET = 1'h0;
	localparam logic [1:0] RANGE_RESET = 2'h0;
	localparam logic [1:0] RANGE_ONE = 2'h1;
	localparam logic [1:0] RANGE_TWO = 2'h2;
	localparam logic [1:0] RANGE_THREE = 2'h3;

	////////////////////////////////////////////////////////////////////////
	// Result store geometry and timing
	localparam int SRAM_AW = 18;
	localparam logic [1:0] GROUP_SAMPLES = 2'h3;
	localparam logic [1:0] SINGLE_SAMPLES = 2'h1;
	localparam int CLK_PERIOD_NS = 50;
	localparam int WR_PULSE_NS = 100;
	localparam int WR_PULSE_CYC =
		(WR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SYNC_STAGES = 3;
	localparam int KIND_COUNT = 9;

	typedef enum logic [3:0]
	{
		SK_X_ZERO,
		SK_Y_ZERO,
		SK_BATT,
		SK_X_SET,
		SK_Y_SET,
		SK_X_RST,
		SK_Y_RST,
		SK_TEMP,
		SK_PRES
	} senctl_kind_t;

	typedef struct packed
	{
		senctl_kind_t kind;
		logic [15:0] data;
	} senctl_sample_t;

	typedef struct packed
	{
		logic [SRAM_AW-1:0] addr;
		logic [15:0] wdata;
		logic drive;
		logic ce_n;
		logic oe_n;
		logic we_n;
	} senctl_sram_t;

	// Byte address of a slot's first result word
	function automatic logic [31:0] kind_base(senctl_kind_t k);
		unique case (k)
			SK_X_ZERO: return X_ZERO_ADDR;
			SK_Y_ZERO: return Y_ZERO_ADDR;
			SK_BATT: return BATT_ADDR;
			SK_X_SET: return X_SET_ADDR;
			SK_Y_SET: return Y_SET_ADDR;
			SK_X_RST: return X_RST_ADDR;
			SK_Y_RST: return Y_RST_ADDR;
			SK_TEMP: return TEMP_ADDR;
			SK_PRES: return PRES_ADDR;
			default: return X_ZERO_ADDR;
		endcase
	endfunction : kind_base

	function automatic logic [1:0] kind_len(senctl_kind_t k);
		if (k == SK_X_ZERO || k == SK_Y_ZERO || k == SK_BATT)
			return SINGLE_SAMPLES;
		return GROUP_SAMPLES;
	endfunction : kind_len

	// SRAM halfword index of a host byte address
	function automatic logic [SRAM_AW-1:0] sram_word(logic [31:0] a);
		logic [31:0] d;
		d = a - CTRL_ADDR;
		return d[SRAM_AW:1];
	endfunction : sram_word

endpackage : senctl_pkg

/* File: verilog/senctl_sram_mux.sv */
`timescale 1ns/100ps

module senctl_sram_mux
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic resetn,
	// Owner select: high hands the bus to the host
	input wire logic done,
	// Candidate drivers
	input wire senctl_pkg::senctl_sram_t dev,
	input wire senctl_pkg::senctl_sram_t host,
	// SRAM pins
	output logic [senctl_pkg::SRAM_AW-1:0] sram_addr,
	output logic [15:0] sram_dq_out,
	output logic sram_dq_oe_n,
	output logic sram_ce_n,
	output logic sram_oe_n,
	output logic sram_we_n
);

	senctl_pkg::senctl_sram_t sel;

	assign sel = done ? host : dev;

	// Registered pins keep glitches off the SRAM strobes at handover
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			sram_addr <= '0;
			sram_dq_out <= 16'h0000;
			sram_dq_oe_n <= 1'h1;
			sram_ce_n <= 1'h1;
			sram_oe_n <= 1'h1;
			sram_we_n <= 1'h1;
		end
		else
		begin
			sram_addr <= sel.addr;
			sram_dq_out <= sel.wdata;
			sram_dq_oe_n <= !sel.drive;
			sram_ce_n <= sel.ce_n;
			sram_oe_n <= sel.oe_n;
			sram_we_n <= sel.we_n;
		end
	end

endmodule : senctl_sram_mux

/* File: verilog/senctl_top.sv */
`timescale 1ns/100ps

module senctl_top
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic resetn,
	// Expansion slot host bus (asynchronous pins)
	input wire logic host_cs_n,
	input wire logic host_we_n,
	input wire logic host_oe_n,
	input wire logic [31:0] host_addr,
	input wire logic [15:0] host_wdata,
	output logic [7:0] host_rdata,
	output logic host_rdata_oe_n,
	// Acquisition engine, same clock
	output logic acquire_start,
	input wire logic acquire_finished,
	input wire logic sample_valid,
	input wire senctl_pkg::senctl_sample_t sample,
	output logic sample_ready,
	// Analog controls
	output logic battery_enable,
	output logic range_one_select_out,
	output logic range_two_select_out,
	output logic range_three_select_out,
	// SRAM pins
	output logic [senctl_pkg::SRAM_AW-1:0] sram_addr,
	output logic [15:0] sram_dq_out,
	output logic sram_dq_oe_n,
	output logic sram_ce_n,
	output logic sram_oe_n,
	output logic sram_we_n
);

	////////////////////////////////////////////////////////////////////////
	// Strobe synchronisers: three stages, accept once stages 2 and 3 agree
	localparam int NSTB = 3;

	logic [NSTB-1:0] stb_pin;
	logic [NSTB-1:0] stb_act;
	logic [NSTB-1:0] stb_prev;

	assign stb_pin = {!host_oe_n, !host_we_n, !host_cs_n};

	genvar g;
	generate
		for (g = 0; g < NSTB; g++)
		begin : g_sync
			logic [senctl_pkg::SYNC_STAGES-1:0] sh;
			always_ff @(posedge core_clk or negedge resetn)
			begin
				if (!resetn)
					sh <= '0;
				else
					sh <= {sh[senctl_pkg::SYNC_STAGES-2:0], stb_pin[g]};
			end
			always_ff @(posedge core_clk or negedge resetn)
			begin
				if (!resetn)
				begin
					stb_act[g] <= 1'h0;
					stb_prev[g] <= 1'h0;
				end
				else
				begin
					if (sh[1] == sh[2])
						stb_act[g] <= sh[2];
					stb_prev[g] <= stb_act[g];
				end
			end
		end
	endgenerate

	wire cs_act = stb_act[0];
	wire we_rise = stb_act[1] && !stb_prev[1];
	wire oe_act = stb_act[2];
	wire is_ctrl = host_addr == senctl_pkg::CTRL_ADDR;
	wire ctrl_wr = cs_act && we_rise && is_ctrl;
	wire ctrl_rd = cs_act && oe_act && is_ctrl;

	////////////////////////////////////////////////////////////////////////
	// Control and status register
	logic exec_req;
	logic done;
	logic batt;
	logic [1:0] range_sel;
	logic finish_pending;
	logic [7:0] ctrl_view;

	wire exec_wr = ctrl_wr && host_wdata[senctl_pkg::EXEC_BIT];
	// A request while a cycle runs is dropped; nothing queues behind it
	wire accept = exec_wr && done;
	wire wr_idle;
	wire finish_now = finish_pending && wr_idle;

	always_comb
	begin
		ctrl_view = 8'h00;
		ctrl_view[senctl_pkg::EXEC_BIT] = exec_req;
		ctrl_view[senctl_pkg::DONE_BIT] = done;
		ctrl_view[senctl_pkg::BATT_BIT] = batt;
		ctrl_view[senctl_pkg::RANGE_HI_BIT] = range_sel[1];
		ctrl_view[senctl_pkg::RANGE_LO_BIT] = range_sel[0];
	end

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			batt <= senctl_pkg::BATT_RESET;
			range_sel <= senctl_pkg::RANGE_RESET;
		end
		else if (ctrl_wr)
		begin
			batt <= host_wdata[senctl_pkg::BATT_BIT];
			range_sel <= {host_wdata[senctl_pkg::RANGE_HI_BIT],
				host_wdata[senctl_pkg::RANGE_LO_BIT]};
		end
	end

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			exec_req <= 1'h0;
			done <= senctl_pkg::DONE_RESET;
			acquire_start <= 1'h0;
		end
		else
		begin
			acquire_start <= accept;
			if (finish_now)
			begin
				done <= 1'h1;
				exec_req <= 1'h0;
			end
			else if (accept)
			begin
				done <= 1'h0;
				exec_req <= 1'h1;
			end
		end
	end

	// Finish is held until the last result write has left the bus
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			finish_pending <= 1'h0;
		else if (finish_now)
			finish_pending <= 1'h0;
		else if (acquire_finished && !done)
			finish_pending <= 1'h1;
	end

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			host_rdata <= 8'h00;
			host_rdata_oe_n <= 1'h1;
		end
		else
		begin
			host_rdata <= ctrl_rd ? ctrl_view : 8'h00;
			host_rdata_oe_n <= !ctrl_rd;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Analog controls
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			battery_enable <= 1'h0;
			range_one_select_out <= 1'h0;
			range_two_select_out <= 1'h0;
			range_three_select_out <= 1'h0;
		end
		else
		begin
			battery_enable <= batt;
			range_one_select_out <= range_sel == senctl_pkg::RANGE_ONE;
			range_two_select_out <= range_sel == senctl_pkg::RANGE_TWO;
			range_three_select_out <=
				range_sel == senctl_pkg::RANGE_THREE;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Result writer
	typedef enum logic [1:0] {WR_IDLE, WR_SETUP, WR_PULSE, WR_HOLD}
		senctl_wr_state_t;

	senctl_wr_state_t wr_state;
	logic [1:0] wr_cnt;
	logic [1:0] fill [senctl_pkg::KIND_COUNT];
	logic [31:0] wr_byte;
	logic [15:0] wr_data;

	wire [3:0] kidx = sample.kind;
	wire take = sample_valid && sample_ready;
	// Samples past a slot's length are accepted but not stored
	wire room = fill[kidx] < senctl_pkg::kind_len(sample.kind);
	wire [31:0] slot_byte = senctl_pkg::kind_base(sample.kind)
		+ {30'h0, fill[kidx]} * senctl_pkg::HALFWORD_STEP;
	wire [1:0] pulse_last = 2'(senctl_pkg::WR_PULSE_CYC - 1);

	assign wr_idle = wr_state == WR_IDLE;
	assign sample_ready = wr_idle && !done;

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			wr_state <= WR_IDLE;
			wr_cnt <= 2'h0;
			wr_byte <= 32'h0000_0000;
			wr_data <= 16'h0000;
		end
		else
		begin
			unique case (wr_state)
				WR_IDLE:
					if (take && room)
					begin
						wr_byte <= slot_byte;
						wr_data <= sample.data;
						wr_state <= WR_SETUP;
					end
				WR_SETUP:
				begin
					wr_cnt <= 2'h0;
					wr_state <= WR_PULSE;
				end
				WR_PULSE:
					if (wr_cnt == pulse_last)
						wr_state <= WR_HOLD;
					else
						wr_cnt <= wr_cnt + 2'h1;
				WR_HOLD:
					wr_state <= WR_IDLE;
			endcase
		end
	end

	generate
		for (g = 0; g < senctl_pkg::KIND_COUNT; g++)
		begin : g_fill
			always_ff @(posedge core_clk or negedge resetn)
			begin
				if (!resetn)
					fill[g] <= 2'h0;
				else if (accept)
					fill[g] <= 2'h0;
				else if (take && room && kidx == g)
					fill[g] <= fill[g] + 2'h1;
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// SRAM ownership
	senctl_pkg::senctl_sram_t dev_bus;
	senctl_pkg::senctl_sram_t host_bus;

	assign dev_bus.addr = senctl_pkg::sram_word(wr_byte);
	assign dev_bus.wdata = wr_data;
	assign dev_bus.drive = !wr_idle;
	assign dev_bus.ce_n = wr_idle;
	assign dev_bus.oe_n = 1'h1;
	assign dev_bus.we_n = wr_state != WR_PULSE;

	// Host drives data on the shared bus itself; only address and control are steered
	assign host_bus.addr = senctl_pkg::sram_word(host_addr);
	assign host_bus.wdata = 16'h0000;
	assign host_bus.drive = 1'h0;
	assign host_bus.ce_n = !(cs_act && !is_ctrl);
	assign host_bus.oe_n = !(oe_act && cs_act && !is_ctrl);
	assign host_bus.we_n = !(stb_act[1] && cs_act && !is_ctrl);

	senctl_sram_mux u_mux
	(
		.core_clk(core_clk),
		.resetn(resetn),
		.done(done),
		.dev(dev_bus),
		.host(host_bus),
		.sram_addr(sram_addr),
		.sram_dq_out(sram_dq_out),
		.sram_dq_oe_n(sram_dq_oe_n),
		.sram_ce_n(sram_ce_n),
		.sram_oe_n(sram_oe_n),
		.sram_we_n(sram_we_n)
	);

endmodule : senctl_top

/* File: tb/senctl_sva.sv */
`timescale 1ns/100ps
module senctl_sva
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic resetn,
	// Watched ports
	input wire logic [7:0] host_rdata,
	input wire logic host_rdata_oe_n,
	input wire logic acquire_start,
	input wire logic sample_valid,
	input wire logic sample_ready,
	input wire logic range_one_select_out,
	input wire logic range_two_select_out,
	input wire logic range_three_select_out,
	input wire logic [senctl_pkg::SRAM_AW-1:0] sram_addr,
	input wire logic sram_dq_oe_n,
	input wire logic sram_ce_n,
	input wire logic sram_we_n
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!resetn);
	sequence take_s;
		sample_valid && sample_ready;
	endsequence
	sequence pulse_s;
		!sram_we_n [*2] ##1 sram_we_n;
	endsequence
	////////////////////////////////////////////////////////////////////////
	a_start_one_cycle: assert property (acquire_start |=> !acquire_start)
		else $error("start pulse too long");
	a_start_opens_port: assert property (acquire_start |-> sample_ready)
		else $error("sample port closed after start");
	a_range_at_most_one: assert property ($onehot0({range_one_select_out,
		range_two_select_out, range_three_select_out}))
		else $error("several range outputs high");
	a_spare_bits_zero: assert property (!host_rdata_oe_n |->
		host_rdata[7:6] == 2'h0 && !host_rdata[3])
		else $error("spare bits read nonzero");
	a_exec_done_apart: assert property (!host_rdata_oe_n |->
		!(host_rdata[5] && host_rdata[4]))
		else $error("execute and done both set");
	a_idle_rdata_zero: assert property (host_rdata_oe_n |-> host_rdata == 8'h00)
		else $error("readback not zero when idle");
	a_port_busy_after: assert property (take_s ##1 !sample_ready |=>
		!sample_ready [*3] ##1 sample_ready)
		else $error("sample port reopened early");
	a_write_pulse_len: assert property ($fell(sram_we_n) && !sram_dq_oe_n
		|-> pulse_s)
		else $error("write pulse length wrong");
	a_write_from_take: assert property ($fell(sram_we_n) && !sram_dq_oe_n
		|-> $past(sample_valid && sample_ready, 3))
		else $error("write without taken sample");
	a_drive_selected: assert property ($fell(sram_dq_oe_n) |-> !sram_ce_n)
		else $error("data driven without select");
	a_addr_steady: assert property (!sram_we_n |-> $stable(sram_addr))
		else $error("address moved during write");
endmodule : senctl_sva

bind senctl_top senctl_sva chk (.core_clk, .resetn, .host_rdata,
	.host_rdata_oe_n, .acquire_start, .sample_valid, .sample_ready,
	.range_one_select_out, .range_two_select_out, .range_three_select_out,
	.sram_addr, .sram_dq_oe_n, .sram_ce_n, .sram_we_n);

/* File: tb/senctl_host.sv */
`timescale 1ns/100ps
module senctl_host
(
	// Clock
	input wire logic core_clk,
	// Slot bus
	output logic host_cs_n,
	output logic host_we_n,
	output logic host_oe_n,
	output logic [31:0] host_addr,
	output logic [15:0] host_wdata,
	input wire logic [7:0] host_rdata
);
	// Strobes held well past the three-flop synchroniser
	localparam int HOLD = 6;
	initial
	begin
		host_cs_n = 1'b1;
		host_we_n = 1'b1;
		host_oe_n = 1'b1;
		host_addr = 32'h0;
		host_wdata = 16'h0;
	end
	task automatic access(input logic wr, input logic [31:0] a,
		input logic [7:0] d, output logic [7:0] q);
		@(negedge core_clk);
		host_addr <= a;
		host_wdata <= {8'h00, d};
		host_cs_n <= 1'b0;
		host_we_n <= !wr;
		host_oe_n <= wr;
		repeat (HOLD) @(negedge core_clk);
		q = host_rdata;
		host_cs_n <= 1'b1;
		host_we_n <= 1'b1;
		host_oe_n <= 1'b1;
		repeat (HOLD) @(negedge core_clk);
		// Released bus shows a changed pattern, not the last value
		host_addr <= ~a;
		host_wdata <= ~{8'h00, d};
	endtask : access
	task automatic write(input logic [7:0] d);
		logic [7:0] q;
		access(1'b1, senctl_pkg::CTRL_ADDR, d, q);
	endtask : write
	task automatic read(output logic [7:0] q);
		access(1'b0, senctl_pkg::CTRL_ADDR, 8'h00, q);
	endtask : read
	// Host read of a result slot once it owns the SRAM
	task automatic fetch(input logic [31:0] a);
		logic [7:0] q;
		access(1'b0, a, 8'h00, q);
	endtask : fetch
	task automatic execute(input logic [1:0] r);
		write(8'h24 | {6'h00, r});
	endtask : execute
	task automatic wait_done(output logic [7:0] q);
		q = 8'h00;
		for (int n = 0; n < 20 && !q[4]; n++)
			read(q);
	endtask : wait_done
endmodule : senctl_host

/* File: tb/tb.sv */
`timescale 1ns/100ps
module tb;
	typedef struct packed
	{
		logic [17:0] a;
		logic [15:0] d;
	} senctl_wr_t;
	logic core_clk, resetn, host_cs_n, host_we_n, host_oe_n;
	logic [31:0] host_addr;
	logic [15:0] host_wdata;
	logic [7:0] host_rdata;
	logic host_rdata_oe_n, acquire_start, acquire_finished, sample_valid;
	senctl_pkg::senctl_sample_t sample;
	logic sample_ready, battery_enable, range_one_select_out;
	logic range_two_select_out, range_three_select_out;
	logic [17:0] sram_addr;
	logic [15:0] sram_dq_out;
	logic sram_dq_oe_n, sram_ce_n, sram_oe_n, sram_we_n;
	int mismatches, num_checks, cycles, starts;
	logic [7:0] rd_q[$];
	senctl_wr_t wr_q[$];
	logic [7:0] v;
	logic [1:0] rng;
	logic rdoe_d, we_d, soe_d;
	logic [17:0] ra_q[$];
	// Byte offsets of the result slots, in kind order
	logic [7:0] base[9] = '{8'h04, 8'h08, 8'h0c, 8'h12, 8'h1a, 8'h22, 8'h2a,
		8'h32, 8'h42};

	senctl_host host (.core_clk, .host_cs_n, .host_we_n, .host_oe_n,
		.host_addr, .host_wdata, .host_rdata);
	senctl_top dut (.core_clk, .resetn, .host_cs_n, .host_we_n, .host_oe_n,
		.host_addr, .host_wdata, .host_rdata, .host_rdata_oe_n, .acquire_start,
		.acquire_finished, .sample_valid, .sample, .sample_ready,
		.battery_enable, .range_one_select_out, .range_two_select_out,
		.range_three_select_out, .sram_addr, .sram_dq_out, .sram_dq_oe_n,
		.sram_ce_n, .sram_oe_n, .sram_we_n);

	////////////////////////////////////////////////////////////////////////
	task automatic cmp8(input string n, input logic [7:0] e,
		input logic [7:0] g);
		num_checks++;
		if (g !== e)
		begin
			mismatches++;
			$display("unexpected %s exp %h got %h", n, e, g);
		end
	endtask : cmp8
	task automatic cmp_wr(input senctl_wr_t e, input senctl_wr_t g);
		num_checks++;
		if (g !== e)
		begin
			mismatches++;
			$display("unexpected sram write exp %h got %h", e, g);
		end
	endtask : cmp_wr
	task automatic conclude;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : conclude
	task automatic send(input int k, input int i);
		logic [15:0] d;
		int n;
		d = 16'($urandom);
		// Writes beyond a slot's length must not reach the SRAM
		if (i < (k < 3 ? 1 : 3))
			wr_q.push_back({18'(base[k] / 2 + i), d});
		@(negedge core_clk);
		sample_valid <= 1'b1;
		sample <= {senctl_pkg::senctl_kind_t'(k), d};
		for (n = 0; n < 20 && sample_ready !== 1'b1; n++)
			@(negedge core_clk);
		@(negedge core_clk);
		sample_valid <= 1'b0;
	endtask : send

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	always @(posedge core_clk)
	begin
		cycles++;
		if (cycles == 8000)
		begin
			mismatches++;
			conclude();
		end
	end
	always @(negedge core_clk)
	begin
		if (acquire_start === 1'b1)
			starts++;
		if (!host_rdata_oe_n && rdoe_d && rd_q.size() > 0)
			cmp8("readback", rd_q.pop_front(), host_rdata);
		if (!sram_we_n && we_d)
			cmp_wr(wr_q.size() > 0 ? wr_q.pop_front() : 'x,
				{sram_addr, sram_dq_out});
		if (!sram_oe_n && soe_d)
		begin
			cmp_wr({ra_q.size() > 0 ? ra_q.pop_front() : 18'h3ffff,
				16'h0000}, {sram_addr, sram_dq_out});
			cmp8("sram owner", 8'h01, {6'h00, sram_ce_n, sram_dq_oe_n});
		end
		rdoe_d <= host_rdata_oe_n;
		we_d <= sram_we_n;
		soe_d <= sram_oe_n;
	end
	initial
	begin
		resetn = 1'b0;
		acquire_finished = 1'b0;
		sample_valid = 1'b0;
		sample = '0;
		rdoe_d = 1'b1;
		we_d = 1'b1;
		soe_d = 1'b1;
		void'($urandom(32'hef44));
		repeat (20) @(negedge core_clk);
		resetn = 1'b1;
		rd_q.push_back(8'h10);
		host.read(v);
		$display("test reset done");
		// Spare bits written high on every pass
		for (int r = 0; r < 8; r++)
		begin
			host.write(8'hc8 | 8'(r));
			rd_q.push_back(8'h10 | 8'(r));
			host.read(v);
			cmp8("battery", 8'(r[2]), 8'(battery_enable));
			cmp8("range", {5'h00, r[1:0] == 2'h3, r[1:0] == 2'h2,
				r[1:0] == 2'h1}, {5'h00, range_three_select_out,
				range_two_select_out, range_one_select_out});
		end
		$display("test range done");
		rng = 2'($urandom);
		host.execute(rng);
		rd_q.push_back(8'h24 | 8'(rng));
		host.read(v);
		host.execute(rng);
		cmp8("starts", 8'h01, 8'(starts));
		cmp8("battery", 8'h01, 8'(battery_enable));
		for (int k = 0; k < 9; k++)
			for (int i = 0; i < 4; i++)
				send(k, i);
		@(negedge core_clk);
		acquire_finished <= 1'b1;
		@(negedge core_clk);
		acquire_finished <= 1'b0;
		host.wait_done(v);
		cmp8("done", 8'h14 | 8'(rng), v);
		cmp8("writes left", 8'h00, 8'(wr_q.size()));
		ra_q.push_back(18'(base[7] / 2));
		host.fetch(senctl_pkg::TEMP_ADDR);
		cmp8("host reads left", 8'h00, 8'(ra_q.size()));
		cmp8("reads left", 8'h00, 8'(rd_q.size()));
		$display("test execute done");
		conclude();
	end
endmodule : tb
